// *** hdl/mac_tx_pkg.sv ***
// Package with the timing constants and state types of the transmit pacing block.
package mac_tx_pkg;
  localparam int BITS_PER_TICK = 4;
  localparam int IPG_BITS = 96;
  localparam int SLOT_BITS = 512;
  localparam int JAM_BITS = 32;
  localparam int IPG_TICKS = (IPG_BITS + BITS_PER_TICK - 1) / BITS_PER_TICK;
  localparam int SLOT_TICKS = SLOT_BITS / BITS_PER_TICK;
  localparam int JAM_TICKS = JAM_BITS / BITS_PER_TICK;
  localparam int MAX_COLL = 16;
  localparam int BACKOFF_LIMIT = 10;
  localparam int BP_ON_TICKS_DEF = 4000;
  localparam int BP_GAP_TICKS_DEF = 4;
  localparam int CNT_W = 17;
  localparam logic [15:0] PAUSE_MAX = 16'hFFFF;
  localparam logic [15:0] PAUSE_ZERO = 16'h0000;
  localparam logic [3:0] JAM_NIBBLE = 4'h5;
  localparam logic [3:0] PREAMBLE_NIBBLE = 4'h5;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  typedef enum logic [2:0] {
    ST_IDLE, ST_IPG, ST_SEND, ST_JAM, ST_DISCARD, ST_BACKOFF, ST_BPCAR, ST_BPGAP
  } tx_state_e;
endpackage

// *** hdl/frame_fifo.sv ***
// Synchronous FIFO with registered full and empty flags.
`timescale 1ns/10ps
`default_nettype none
module frame_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("frame_fifo depth must be a power of two of at least two");
    end
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        full;
    logic                        empty;
    logic                        room;
  } fifo_s;
  fifo_s s;
  fifo_s next_s;
  logic push;
  logic pop;
  assign push = in_valid && !s.full;
  assign pop = out_ready && !s.empty;
  assign in_ready = s.room;
  assign out_valid = !s.empty;
  assign out_data = s.mem[s.rp];
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.full = (next_s.cnt == (AW+1)'(DEPTH));
    next_s.empty = (next_s.cnt == '0);
    next_s.room = !next_s.full;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{mem: '0, wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1, room: 1'b1};
    end else begin
      s <= next_s;
    end
  end
  a_fifo_flags: assert property (@(posedge clk) disable iff (!reset_n)
    s.full |-> !s.empty && s.cnt == (AW+1)'(DEPTH)) else $error("fifo flags wrong");
endmodule
`default_nettype wire

// *** hdl/mac_tx_pacing_flow_control.sv ***
// Transmit pacing, collision back-off, pause flow control and backpressure.
`timescale 1ns/10ps
`default_nettype none
module mac_tx_pacing_flow_control #(
  parameter int DW = 4,
  parameter int LEVEL_W = 13,
  parameter int LEVEL_HI = 6144,
  parameter int LEVEL_LO = 4096,
  parameter int BP_ON_TICKS = mac_tx_pkg::BP_ON_TICKS_DEF,
  parameter int BP_GAP_TICKS = mac_tx_pkg::BP_GAP_TICKS_DEF,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                tick,
  input  wire logic                full_duplex,
  input  wire logic                autoneg_en,
  input  wire logic                col,
  input  wire logic                crs,
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire logic [DW-1:0]       in_data,
  input  wire logic                in_last,
  input  wire logic [LEVEL_W-1:0]  buf_level,
  input  wire logic                pause_rx_valid,
  input  wire logic [15:0]         pause_rx_quanta,
  input  wire logic                fc_ack,
  output logic                     fc_req,
  output logic [15:0]              fc_quanta,
  output logic                     paused,
  output logic                     flow_on,
  output logic                     tx_en,
  output logic [DW-1:0]            tx_data,
  output logic                     tx_preamble,
  output logic                     frame_retry,
  output logic                     frame_drop
);
  import mac_tx_pkg::*;
  initial begin
    if (DW != 4 || LEVEL_LO >= LEVEL_HI || LEVEL_HI >= (1 << LEVEL_W) || BP_ON_TICKS < 1
        || BP_GAP_TICKS < 1 || BP_ON_TICKS >= (1 << CNT_W) || BP_GAP_TICKS >= (1 << CNT_W)) begin
      $error("mac_tx_pacing_flow_control parameters out of range");
    end
  end
  typedef struct packed {
    tx_state_e   st;
    logic [CNT_W-1:0] cnt;
    logic [4:0]  coll;
    logic [7:0]  slot;
    logic [15:0] lfsr;
    logic [15:0] pq;
    logic [6:0]  psub;
    logic        paused;
    logic        flow_on;
    logic        fc_req;
    logic [15:0] fc_quanta;
    logic        tx_en;
    logic [DW-1:0] tx_data;
    logic        tx_preamble;
    logic        retry;
    logic        drop;
    logic        col_m;
    logic        col_s;
    logic        crs_m;
    logic        crs_s;
  } ctl_s;
  ctl_s s;
  ctl_s next_s;
  logic          f_valid;
  logic          f_ready;
  logic [DW:0]   f_data;
  logic          f_last;
  logic          pop;
  logic          bp_want;
  logic          can_send;
  logic          half_col;
  logic [3:0]    bo_exp;
  logic [9:0]    bo_mask;
  frame_fifo #(.WIDTH(DW+1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_last, in_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  assign f_last = f_data[DW];
  assign f_ready = pop;
  assign bp_want = !full_duplex && autoneg_en && s.flow_on;
  assign can_send = f_valid && (s.pq == PAUSE_ZERO);
  assign half_col = s.col_s && !full_duplex;
  assign bo_exp = (s.coll > 5'(BACKOFF_LIMIT)) ? 4'(BACKOFF_LIMIT) : s.coll[3:0];
  assign bo_mask = 10'h3FF >> (4'(BACKOFF_LIMIT) - bo_exp);
  always_comb begin
    next_s = s;
    pop = 1'b0;
    next_s.retry = 1'b0;
    next_s.drop = 1'b0;
    next_s.col_m = col;
    next_s.col_s = s.col_m;
    next_s.crs_m = crs;
    next_s.crs_s = s.crs_m;
    next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
    if (s.fc_req && fc_ack) begin
      next_s.fc_req = 1'b0;
    end
    if (!s.flow_on && buf_level >= LEVEL_W'(LEVEL_HI)) begin
      next_s.flow_on = 1'b1;
      if (full_duplex) begin
        next_s.fc_req = 1'b1;
        next_s.fc_quanta = PAUSE_MAX;
      end
    end else if (s.flow_on && buf_level <= LEVEL_W'(LEVEL_LO)) begin
      next_s.flow_on = 1'b0;
      if (full_duplex) begin
        next_s.fc_req = 1'b1;
        next_s.fc_quanta = PAUSE_ZERO;
      end
    end
    if (pause_rx_valid) begin
      next_s.pq = pause_rx_quanta;
      next_s.psub = '0;
    end else if (tick && s.pq != PAUSE_ZERO) begin
      next_s.psub = s.psub + 1'b1;
      if (s.psub == 7'(SLOT_TICKS - 1)) begin
        next_s.pq = s.pq - 1'b1;
      end
    end
    next_s.paused = (next_s.pq != PAUSE_ZERO);
    case (s.st)
      ST_IDLE: begin
        if (can_send && (full_duplex || !s.crs_s)) begin
          next_s.st = ST_SEND;
          next_s.slot = '0;
        end else if (bp_want) begin
          next_s.st = ST_BPCAR;
          next_s.cnt = '0;
        end
      end
      ST_SEND: begin
        if (tick && half_col) begin
          next_s.tx_data = JAM_NIBBLE;
          next_s.st = ST_JAM;
          next_s.cnt = '0;
          if (s.slot >= 8'(SLOT_TICKS)) begin
            next_s.drop = 1'b1;
            next_s.coll = '0;
          end else if (s.coll == 5'(MAX_COLL - 1)) begin
            next_s.drop = 1'b1;
            next_s.coll = '0;
          end else begin
            next_s.retry = 1'b1;
            next_s.coll = s.coll + 1'b1;
          end
        end else if (tick && f_valid) begin
          pop = 1'b1;
          next_s.tx_en = 1'b1;
          next_s.tx_preamble = 1'b0;
          next_s.tx_data = f_data[DW-1:0];
          if (s.slot != 8'hFF) begin
            next_s.slot = s.slot + 1'b1;
          end
          if (f_last) begin
            next_s.st = ST_IPG;
            next_s.cnt = '0;
            next_s.coll = '0;
          end
        end
      end
      ST_JAM: begin
        if (tick) begin
          next_s.cnt = s.cnt + 1'b1;
          if (s.cnt == CNT_W'(JAM_TICKS - 1)) begin
            next_s.tx_en = 1'b0;
            next_s.st = ST_DISCARD;
          end
        end
      end
      ST_DISCARD: begin
        if (f_valid) begin
          pop = 1'b1;
          if (f_last) begin
            next_s.cnt = '0;
            if (s.coll == '0) begin
              next_s.st = ST_IPG;
            end else if (bp_want) begin
              next_s.st = ST_BPCAR;
            end else begin
              next_s.st = ST_BACKOFF;
              next_s.cnt = {bo_mask & s.lfsr[9:0], 7'h00};
            end
          end
        end
      end
      ST_BACKOFF: begin
        if (tick) begin
          if (s.cnt == '0) begin
            next_s.st = ST_IPG;
          end else begin
            next_s.cnt = s.cnt - 1'b1;
          end
        end
      end
      ST_IPG: begin
        if (tick) begin
          next_s.tx_en = 1'b0;
          next_s.tx_preamble = 1'b0;
          if (!full_duplex && s.crs_s) begin
            next_s.cnt = '0;
          end else if (s.cnt == CNT_W'(IPG_TICKS - 1)) begin
            next_s.st = ST_IDLE;
          end else begin
            next_s.cnt = s.cnt + 1'b1;
          end
        end
      end
      ST_BPCAR: begin
        if (can_send || !bp_want) begin
          next_s.st = ST_IPG;
          next_s.cnt = '0;
          next_s.tx_en = 1'b0;
          next_s.tx_preamble = 1'b0;
        end else if (tick) begin
          next_s.tx_en = 1'b1;
          next_s.tx_preamble = 1'b1;
          next_s.tx_data = PREAMBLE_NIBBLE;
          next_s.cnt = s.cnt + 1'b1;
          if (s.cnt == CNT_W'(BP_ON_TICKS - 1)) begin
            next_s.st = ST_BPGAP;
            next_s.cnt = '0;
          end
        end
      end
      ST_BPGAP: begin
        if (tick) begin
          next_s.tx_en = 1'b0;
          next_s.tx_preamble = 1'b0;
          next_s.cnt = s.cnt + 1'b1;
          if (s.cnt == CNT_W'(BP_GAP_TICKS - 1)) begin
            next_s.st = (bp_want && !can_send) ? ST_BPCAR : ST_IPG;
            next_s.cnt = '0;
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{st: ST_IDLE, lfsr: LFSR_SEED, fc_quanta: PAUSE_ZERO, tx_data: '0, default: '0};
    end else begin
      s <= next_s;
    end
  end
  assign fc_req = s.fc_req;
  assign fc_quanta = s.fc_quanta;
  assign paused = s.paused;
  assign flow_on = s.flow_on;
  assign tx_en = s.tx_en;
  assign tx_data = s.tx_data;
  assign tx_preamble = s.tx_preamble;
  assign frame_retry = s.retry;
  assign frame_drop = s.drop;
  logic [5:0] gap_ticks;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_ticks <= 6'h3F;
    end else if (s.tx_en) begin
      gap_ticks <= '0;
    end else if (tick && gap_ticks != 6'h3F) begin
      gap_ticks <= gap_ticks + 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ipg_min_gap: assert property (
    $rose(s.tx_en) && !next_s.tx_preamble && !s.tx_preamble |-> gap_ticks >= 6'(IPG_TICKS - 1))
    else $error("frame started inside the gap");
  a_gap_carrier: assert property (
    s.st == ST_IPG && tick && !full_duplex && s.crs_s |=> s.cnt == '0)
    else $error("gap not restarted by carrier");
  a_backoff_slots: assert property (
    s.st == ST_DISCARD && f_valid && f_last && s.coll != '0 && !bp_want
    |=> s.st == ST_BACKOFF && s.cnt[6:0] == 7'h00) else $error("back-off not slot aligned");
  a_coll_limit: assert property (
    s.st == ST_SEND && tick && half_col && s.coll == 5'(MAX_COLL - 1) && s.slot < 8'(SLOT_TICKS)
    |=> frame_drop && !frame_retry && s.coll == '0) else $error("sixteenth collision kept");
  a_late_drop: assert property (
    s.st == ST_SEND && tick && half_col && s.slot >= 8'(SLOT_TICKS) |=> frame_drop && !frame_retry)
    else $error("late collision retried");
  a_pause_hold: assert property (
    s.st == ST_IDLE && s.pq != PAUSE_ZERO |=> s.st != ST_SEND) else $error("sent while paused");
  a_pause_reload: assert property (
    pause_rx_valid |=> s.pq == $past(pause_rx_quanta) && s.psub == '0)
    else $error("pause timer not reloaded");
  a_paused_no_bp_frame: assert property (
    s.pq != PAUSE_ZERO && s.st != ST_SEND |=> s.st != ST_SEND)
    else $error("frame started while paused");
  a_pause_max: assert property (
    !s.flow_on && buf_level >= LEVEL_W'(LEVEL_HI) && full_duplex
    |=> fc_req && fc_quanta == PAUSE_MAX) else $error("no maximum pause");
  a_pause_zero: assert property (
    s.flow_on && buf_level <= LEVEL_W'(LEVEL_LO) && full_duplex
    |=> fc_req && fc_quanta == PAUSE_ZERO) else $error("no zero pause");
  a_hyst_band: assert property (
    s.flow_on && buf_level > LEVEL_W'(LEVEL_LO) |=> s.flow_on) else $error("released inside band");
  a_bp_start: assert property (
    s.st == ST_IDLE && bp_want && !can_send |=> s.st == ST_BPCAR) else $error("backpressure idle");
  a_bp_preamble: assert property (
    s.st == ST_BPCAR && tick && bp_want && !can_send |=> tx_preamble && tx_data == PREAMBLE_NIBBLE)
    else $error("no preamble");
  a_bp_gap_len: assert property (
    $fell(tx_preamble) && s.st == ST_BPGAP |-> !tx_preamble [*3] ##1 !tx_preamble)
    else $error("silent gap too short");
  a_bp_yield: assert property (
    s.st == ST_BPCAR && can_send |=> s.st == ST_IPG && !tx_preamble) else $error("frame not sent");
  a_bp_resume: assert property (
    s.st == ST_IDLE && bp_want && !f_valid |=> s.st == ST_BPCAR) else $error("carrier not resumed");
  a_bp_nobackoff: assert property (
    s.st == ST_DISCARD && f_valid && f_last && s.coll != '0 && bp_want |=> s.st == ST_BPCAR)
    else $error("back-off under backpressure");
  a_bp_on_limit: assert property (
    s.st == ST_BPCAR |-> s.cnt < CNT_W'(BP_ON_TICKS)) else $error("carrier too long");
  a_level_param: assert property (
    $rose(s.flow_on) |-> $past(buf_level) >= LEVEL_W'(LEVEL_HI)) else $error("early flow control");
  c_retry: cover property (frame_retry);
  c_late_drop: cover property (s.st == ST_SEND && half_col && tick && s.slot >= 8'(SLOT_TICKS));
  c_bp_gap: cover property (s.st == ST_BPGAP ##1 s.st == ST_BPCAR);
  c_pause: cover property (pause_rx_valid && s.pq != PAUSE_ZERO);
endmodule
`default_nettype wire

// *** bench/phy_model.sv ***
// Behavioural model of the PHY and the remote station on the far side of the link.
`timescale 1ns/10ps
`default_nettype none
module phy_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic tx_en,
  input  wire logic remote_on,
  output logic      crs,
  output logic      col
);
  typedef struct packed {
    logic crs;
    logic col;
  } phy_s;
  phy_s state;
  phy_s next_state;
  // Carrier follows own and remote transmission; collision needs both at once.
  always_comb begin
    next_state.crs = tx_en | remote_on;
    next_state.col = tx_en & remote_on;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign crs = state.crs;
  assign col = state.col;
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking testbench of the transmit pacing and flow control block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import mac_tx_pkg::*;
  localparam int HI = 6144;
  localparam int LO = 4096;
  localparam int BP_ON = 20;
  localparam int BP_GAP = 2;
  localparam int B_FLOW = 0, B_PAUSE = 1, B_FC = 2, B_EN = 3, B_PRE = 4, B_RETRY = 5, B_DROP = 6;
  logic        clk, reset_n, tick, full_duplex, autoneg_en, col, crs, remote_on;
  logic        in_valid, in_ready, in_last, pause_rx_valid, fc_ack, fc_req, paused, flow_on;
  logic        tx_en, tx_preamble, frame_retry, frame_drop, prev_en;
  logic [3:0]  in_data, tx_data, prev_data;
  logic [12:0] buf_level;
  logic [15:0] pause_rx_quanta, fc_quanta;
  logic [6:0]  mon;
  logic [4:0]  txq[$];
  logic [3:0]  seen[$];
  int          n_fail, check_count, low_run, gap;
  assign mon = {frame_drop, frame_retry, tx_preamble, tx_en, fc_req, paused, flow_on};

  mac_tx_pacing_flow_control #(.BP_ON_TICKS(BP_ON), .BP_GAP_TICKS(BP_GAP))
    u_mac_tx_pacing_flow_control (
    .clk(clk), .reset_n(reset_n), .tick(tick), .full_duplex(full_duplex),
    .autoneg_en(autoneg_en), .col(col), .crs(crs), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_last(in_last), .buf_level(buf_level),
    .pause_rx_valid(pause_rx_valid), .pause_rx_quanta(pause_rx_quanta), .fc_ack(fc_ack),
    .fc_req(fc_req), .fc_quanta(fc_quanta), .paused(paused), .flow_on(flow_on),
    .tx_en(tx_en), .tx_data(tx_data), .tx_preamble(tx_preamble),
    .frame_retry(frame_retry), .frame_drop(frame_drop));
  phy_model u_phy_model (.clk(clk), .reset_n(reset_n), .tx_en(tx_en),
    .remote_on(remote_on), .crs(crs), .col(col));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) tick <= reset_n && !tick;
  // Feeds queued nibbles into the stream input, one per accepted cycle.
  always @(posedge clk) begin
    if (in_valid && in_ready) void'(txq.pop_front());
    if (txq.size() > 0) begin
      in_valid <= 1'b1;
      {in_last, in_data} <= txq[0];
    end else begin
      in_valid <= 1'b0;
    end
  end
  // Records frame nibbles and the idle length before each transmission.
  always @(posedge clk) begin
    if (tx_en && !tx_preamble && (!prev_en || tx_data !== prev_data)) seen.push_back(tx_data);
    if (tx_en && !prev_en) gap <= low_run;
    low_run <= tx_en ? 0 : low_run + 1;
    prev_en <= tx_en;
    prev_data <= tx_data;
  end

  task automatic print_verdict();
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic wait_sig(input int b, input logic v, input int lim, output int k);
    for (k = 0; k < lim && mon[b] !== v; k++) @(negedge clk);
    if (mon[b] !== v) begin
      $display("unexpected timeout bit %0d expected %b seen %b", b, v, mon[b]);
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic hold(input string what, input int b, input logic v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge clk);
      if (mon[b] !== v) ok = 1'b0;
    end
    check(what, 1, ok);
  endtask
  task automatic cfg(input logic fd, input logic an, input int lvl);
    @(posedge clk);
    full_duplex <= fd;
    autoneg_en <= an;
    buf_level <= lvl[12:0];
    @(negedge clk);
  endtask
  task automatic push(input int n, input logic [3:0] base);
    for (int i = 0; i < n; i++) txq.push_back({i == n - 1, base + i[3:0]});
  endtask
  task automatic frame_ok(input int n, input logic [3:0] base);
    int k;
    wait_sig(B_EN, 0, 400, k);
    @(negedge clk);
    check("nibble_count", n, seen.size());
    for (int i = 0; i < n; i++) check("tx_nibble", base + i[3:0], seen[i]);
    seen.delete();
  endtask
  task automatic ack();
    @(posedge clk) fc_ack <= 1'b1;
    @(posedge clk) fc_ack <= 1'b0;
    @(negedge clk);
    check("fc_req_cleared", 0, fc_req);
  endtask
  task automatic pulse(input logic [15:0] q);
    @(posedge clk);
    pause_rx_valid <= 1'b1;
    pause_rx_quanta <= q;
    @(posedge clk) pause_rx_valid <= 1'b0;
    repeat (2) @(negedge clk);
    check("paused_on_load", 1, paused); // timer loaded
  endtask
  task automatic remote(input logic v);
    @(posedge clk) remote_on <= v;
  endtask

  task automatic t_ipg();
    int k;
    cfg(1'b1, 1'b0, 0);
    push(4, 4'h1);
    push(4, 4'h5);
    wait_sig(B_EN, 1, 200, k);
    wait_sig(B_EN, 0, 100, k);
    wait_sig(B_EN, 1, 400, k);
    @(negedge clk);
    check("ipg_gap", 1, gap >= 2 * IPG_TICKS); // gap length
    frame_ok(8, 4'h1);
  endtask
  task automatic t_flow();
    int k;
    cfg(1'b1, 1'b0, HI);
    wait_sig(B_FC, 1, 10, k);
    check("fc_quanta_max", PAUSE_MAX, fc_quanta); // largest pause
    check("flow_on_set", 1, flow_on); // high level
    ack();
    cfg(1'b1, 1'b0, 5000);
    hold("no_release_in_band", B_FC, 0, 20); // band holds
    check("flow_on_held", 1, flow_on); // band holds
    cfg(1'b1, 1'b0, LO);
    wait_sig(B_FC, 1, 10, k);
    check("fc_quanta_zero", PAUSE_ZERO, fc_quanta); // zero pause
    check("flow_on_clear", 0, flow_on); // low level
    ack();
    cfg(1'b1, 1'b0, 5000);
    hold("stays_off_in_band", B_FLOW, 0, 20); // band holds
  endtask
  task automatic t_pause();
    int k;
    pulse(16'h0001);
    repeat (100) @(negedge clk);
    pulse(16'h0002);
    push(4, 4'h1);
    wait_sig(B_EN, 1, 2000, k);
    check("pause_reload_wait", 1, k >= 4 * SLOT_TICKS - 8); // reload value
    check("paused_at_start", 0, paused); // no frame paused
    frame_ok(4, 4'h1);
  endtask
  task automatic t_bp();
    int k;
    cfg(1'b0, 1'b0, HI);
    hold("no_bp_without_an", B_PRE, 0, 60); // needs autoneg
    check("no_fc_half", 0, fc_req); // carrier only
    cfg(1'b0, 1'b1, HI);
    wait_sig(B_PRE, 1, 20, k);
    check("bp_tx_en", 1, tx_en); // carrier sent
    check("bp_nibble", PREAMBLE_NIBBLE, tx_data); // preamble data
    wait_sig(B_EN, 0, 2 * BP_ON + 20, k);
    check("bp_on_len", 1, k >= 2 * BP_ON - 2 && k <= 2 * BP_ON + 4); // carrier length
    wait_sig(B_EN, 1, 2 * BP_GAP + 10, k);
    check("bp_gap_len", 1, k >= 2 * BP_GAP - 2 && k <= 2 * BP_GAP + 2); // short silence
    push(4, 4'h6);
    wait_sig(B_PRE, 0, 60, k);
    wait_sig(B_EN, 0, 5, k);
    wait_sig(B_EN, 1, 200, k);
    check("frame_not_preamble", 0, tx_preamble); // own frame
    frame_ok(4, 4'h6); // own frame
    wait_sig(B_PRE, 1, 200, k); // carrier resumes
    push(8, 4'h6);
    wait_sig(B_PRE, 0, 60, k);
    wait_sig(B_EN, 1, 200, k);
    repeat (4) @(negedge clk);
    remote(1'b1);
    wait_sig(B_RETRY, 1, 20, k);
    wait_sig(B_PRE, 1, 40, k); // no back-off
    remote(1'b0);
    seen.delete();
    cfg(1'b0, 1'b1, LO);
    wait_sig(B_PRE, 0, 100, k);
    hold("bp_released", B_EN, 0, 80); // ends when freed
  endtask
  task automatic t_coll();
    int k;
    cfg(1'b0, 1'b0, 0);
    push(8, 4'h6);
    wait_sig(B_EN, 1, 200, k);
    repeat (4) @(negedge clk);
    remote(1'b1);
    wait_sig(B_RETRY, 1, 20, k); // retry taken
    check("early_no_drop", 0, frame_drop); // retry taken
    check("jam_nibble", JAM_NIBBLE, tx_data); // jam before retry
    repeat (60) @(negedge clk);
    remote(1'b0);
    seen.delete();
    push(8, 4'h6);
    wait_sig(B_EN, 1, 3000, k);
    check("ipg_after_crs", 1, k >= 2 * IPG_TICKS - 1); // gap from carrier
    frame_ok(8, 4'h6); // frame resent
  endtask
  task automatic t_late();
    int k;
    push(200, 4'h0);
    wait_sig(B_EN, 1, 200, k);
    repeat (300) @(negedge clk);
    remote(1'b1);
    wait_sig(B_DROP, 1, 20, k); // late drop
    check("late_no_retry", 0, frame_retry); // late drop
    repeat (20) @(negedge clk);
    remote(1'b0);
    for (k = 0; k < 400 && txq.size() > 0; k++) @(negedge clk);
    hold("late_not_resent", B_EN, 0, 300); // no retry
  endtask

  initial begin
    {reset_n, full_duplex, autoneg_en, remote_on, fc_ack, pause_rx_valid} = '0;
    {buf_level, pause_rx_quanta} = '0;
    n_fail = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check("in_ready_reset", 1, in_ready);
    t_ipg();
    t_flow();
    t_pause();
    t_bp();
    t_coll();
    t_late();
    print_verdict();
  end
endmodule
`default_nettype wire
